// ---- rtl/afeav_pkg.sv ----
`default_nettype none

package afeav_pkg;

  // Front-end clock and conversion timing
  localparam int unsigned CLK_FREQ_MHZ    = 40;
  localparam int unsigned CONV_TIME_US    = 50;
  localparam int unsigned CONV_CYCLES     = CONV_TIME_US * CLK_FREQ_MHZ;

  // Serial word layout
  localparam int unsigned SPI_WORD_BITS   = 32;
  localparam int unsigned SPI_ADDR_BITS   = 8;
  localparam int unsigned REG_DATA_BITS   = 24;
  localparam logic [4:0]  SPI_LAST_ADDR_BIT = 5'h07;
  localparam logic [4:0]  SPI_LAST_BIT      = 5'h1f;

  // Result format
  localparam int unsigned CODE_BITS       = 22;
  localparam int unsigned SUM_BITS        = 30;

  // Register offsets
  localparam logic [7:0] ADDR_CONTROL0       = 8'h00;
  localparam logic [7:0] ADDR_TMR_FIRST      = 8'h01;
  localparam logic [7:0] ADDR_TMR_LAST       = 8'h1d;
  localparam logic [7:0] ADDR_FIRST_CONTROL  = 8'h1e;
  localparam logic [7:0] ADDR_AVG_COUNT      = 8'h20;
  localparam logic [7:0] ADDR_LED_CURRENT    = 8'h22;
  localparam logic [7:0] ADDR_PHASE_ONE      = 8'h2a;
  localparam logic [7:0] ADDR_PHASE_TWO      = 8'h2b;
  localparam logic [7:0] ADDR_PHASE_THREE    = 8'h2c;
  localparam logic [7:0] ADDR_PHASE_FOUR     = 8'h2d;
  localparam logic [7:0] ADDR_COMBINED_FIRST = 8'h2e;
  localparam logic [7:0] ADDR_COMBINED_SECOND = 8'h2f;

  // Field positions
  localparam int unsigned BIT_SPI_READ      = 0;
  localparam int unsigned BIT_SW_RESET      = 3;
  localparam int unsigned BIT_TIMER_ENABLE  = 0;

  // Timing word indices (offset of each timing register)
  localparam int unsigned TMR_RED_LED_ST    = 3;
  localparam int unsigned TMR_RED_LED_END   = 4;
  localparam int unsigned TMR_RED_AMB_ST    = 5;
  localparam int unsigned TMR_RED_AMB_END   = 6;
  localparam int unsigned TMR_IR_LED_ST     = 9;
  localparam int unsigned TMR_IR_LED_END    = 10;
  localparam int unsigned TMR_IR_AMB_ST     = 11;
  localparam int unsigned TMR_IR_AMB_END    = 12;
  localparam int unsigned TMR_CONV_RST_ST   = 21;
  localparam int unsigned TMR_PERIOD        = 29;

  // Values after reset
  localparam logic [15:0] TMR_RESET [1:29] = '{
    16'h17a2, 16'h1f3e, 16'h1770, 16'h1f3f, 16'h0032, 16'h07ce, 16'h0802,
    16'h0f9e, 16'h07d0, 16'h0f9f, 16'h0fd2, 16'h176e, 16'h0004, 16'h07cf,
    16'h07d4, 16'h0f9f, 16'h0fa4, 16'h176f, 16'h1774, 16'h1f3f, 16'h0000,
    16'h0003, 16'h07d0, 16'h07d3, 16'h0fa0, 16'h0fa3, 16'h1770, 16'h1773,
    16'h1f3f};
  localparam logic [7:0]  AVG_COUNT_RESET   = 8'h02;
  localparam logic [15:0] LED_CURRENT_RESET = 16'h0000;

endpackage

`default_nettype wire

// ---- rtl/afeav_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module afeav_fifo
  import afeav_pkg::*;
#(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ---- rtl/afeav_top.sv ----
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Conversion phase starts when converter reset falls; each conversion lasts 50 us.
// - Result is a 22-bit twos-complement code in low bits of 24-bit word.
// - Results are twos complement and shifted out to the host MSB first.
// - Upper two bits sign-extend the code so the 24-bit word is valid.
// - One code step is 1.2 V over 2^21; full scale maps to extreme codes.
// - Samples of a phase accumulate per completed conversion and average to one result.
// - Samples averaged per phase default to 2.
// - Phase average is committed at the next rising edge of converter reset.
// - Pulses at 25, 50, 75 percent commit to phase one, two, three results.
// - Start-of-period pulse commits pending average to phase four result.
// - Same pulse updates both combined results from their phase pairs.
// - Ready strobe rises once all six results valid; host reads afterwards.
// - LED current uses 8-bit setting per LED; maximum equals 50 mA.
// - Red and infrared current settings share one 16-bit register, red in the low byte.
// - LED drive-active is low throughout every ambient measurement phase.
// - 16-bit period count ends the period; timing count restarts at zero.
module afeav_top
  import afeav_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
)
(
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  // Serial register port
  input  wire logic                 SPI_SCLK,
  input  wire logic                 SPI_CS_N,
  input  wire logic                 SPI_MOSI,
  output logic                      SPI_MISO,
  // Converter
  output logic                      ADC_RESET,
  output logic                      ADC_CONV_START,
  input  wire logic                 ADC_SAMPLE_VALID,
  output logic                      ADC_SAMPLE_READY,
  input  wire logic [CODE_BITS-1:0] ADC_SAMPLE_DATA,
  output logic                      ADC_RDY,
  // LED drive
  output logic                      LED_DRIVE_ACTIVE,
  output logic                      RED_EMITTER_ON,
  output logic                      INFRARED_EMITTER_ON,
  output logic [7:0]                RED_EMITTER_CURRENT,
  output logic [7:0]                INFRARED_EMITTER_CURRENT
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic        spi_read;
  logic        timing_engine_enable;
  logic [15:0] tmr [1:29];
  logic [7:0]  avg_count;
  logic [15:0] led_current_source;
  logic [23:0] result [6];
  logic [3:0]  phase_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port, sampled on the system clock

  logic        sclk_q;
  logic [4:0]  bit_cnt;
  logic [30:0] shift_in;
  logic [23:0] shift_out;
  wire         sclk_rise = SPI_SCLK & ~sclk_q & ~SPI_CS_N;
  wire         sclk_fall = ~SPI_SCLK & sclk_q & ~SPI_CS_N;
  wire  [7:0]  rd_addr   = {shift_in[6:0], SPI_MOSI};
  wire         wr_stb    = sclk_rise & (bit_cnt == SPI_LAST_BIT);
  wire  [7:0]  wr_addr   = shift_in[30:23];
  wire  [23:0] wr_data   = {shift_in[22:0], SPI_MOSI};
  wire         wr_ctrl0  = wr_stb & (wr_addr == ADDR_CONTROL0);
  // Other registers are writable only outside readback mode
  wire         wr_other  = wr_stb & ~spi_read;
  wire         sw_reset  = wr_ctrl0 & wr_data[BIT_SW_RESET];
  wire         wr_tmr    = wr_other & (wr_addr >= ADDR_TMR_FIRST) & (wr_addr <= ADDR_TMR_LAST);
  wire         wr_fctl   = wr_other & (wr_addr == ADDR_FIRST_CONTROL);
  wire         wr_avg    = wr_other & (wr_addr == ADDR_AVG_COUNT);
  wire         wr_led    = wr_other & (wr_addr == ADDR_LED_CURRENT);

  wire         rd_is_tmr = (rd_addr >= ADDR_TMR_FIRST) & (rd_addr <= ADDR_TMR_LAST);
  wire         rd_is_res = (rd_addr >= ADDR_PHASE_ONE) & (rd_addr <= ADDR_COMBINED_SECOND);
  wire  [2:0]  rd_res_ix = 3'(rd_addr - ADDR_PHASE_ONE);
  wire  [23:0] rd_data   =
    rd_is_res                        ? result[rd_res_ix] :
    rd_is_tmr                        ? {8'h00, tmr[rd_addr[4:0]]} :
    (rd_addr == ADDR_CONTROL0)       ? {23'h000000, spi_read} :
    (rd_addr == ADDR_FIRST_CONTROL)  ? {23'h000000, timing_engine_enable} :
    (rd_addr == ADDR_AVG_COUNT)      ? {16'h0000, avg_count} :
    (rd_addr == ADDR_LED_CURRENT)    ? {8'h00, led_current_source} :
                                       24'h000000;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      sclk_q    <= 1'b0;
      bit_cnt   <= '0;
      shift_in  <= '0;
      shift_out <= '0;
      SPI_MISO  <= 1'b0;
    end
    else
    begin
      sclk_q <= SPI_SCLK;
      if (SPI_CS_N)
        bit_cnt <= '0;
      else if (sclk_rise)
        bit_cnt <= bit_cnt + 1'b1;
      if (sclk_rise)
        shift_in <= {shift_in[29:0], SPI_MOSI};
      if (sclk_rise & (bit_cnt == SPI_LAST_ADDR_BIT) & spi_read)
        shift_out <= rd_data;
      else if (sclk_fall)
        shift_out <= {shift_out[22:0], 1'b0};
      if (sclk_fall)
        SPI_MISO <= shift_out[23];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-written registers

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      spi_read             <= 1'b0;
      timing_engine_enable <= 1'b0;
      avg_count            <= AVG_COUNT_RESET;
      led_current_source   <= LED_CURRENT_RESET;
      for (int i = 1; i <= 29; i++)
        tmr[i] <= TMR_RESET[i];
    end
    else if (sw_reset)
    begin
      spi_read             <= 1'b0;
      timing_engine_enable <= 1'b0;
      avg_count            <= AVG_COUNT_RESET;
      led_current_source   <= LED_CURRENT_RESET;
      for (int i = 1; i <= 29; i++)
        tmr[i] <= TMR_RESET[i];
    end
    else
    begin
      if (wr_ctrl0)
        spi_read <= wr_data[BIT_SPI_READ];
      if (wr_fctl)
        timing_engine_enable <= wr_data[BIT_TIMER_ENABLE];
      if (wr_avg)
        avg_count <= wr_data[7:0];
      if (wr_led)
        led_current_source <= wr_data[15:0];
      if (wr_tmr)
        tmr[wr_addr[4:0]] <= wr_data[15:0];
    end
  end

  // Eight-bit code per emitter; full code is the 50 mA ceiling
  assign RED_EMITTER_CURRENT      = led_current_source[7:0];
  assign INFRARED_EMITTER_CURRENT = led_current_source[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // Timing engine

  logic [15:0] cnt;
  wire         period_end = (cnt >= tmr[TMR_PERIOD]);
  logic [3:0]  rst_win;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      cnt <= '0;
    else if (~timing_engine_enable | period_end)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  function automatic logic in_window(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e);
    in_window = (c >= s) & (c <= e);
  endfunction

  for (genvar k = 0; k < 4; k++)
  begin : g_rst
    assign rst_win[k] = timing_engine_enable
                      & in_window(cnt, tmr[TMR_CONV_RST_ST + 2*k], tmr[TMR_CONV_RST_ST + 2*k + 1]);
  end

  wire red_win = in_window(cnt, tmr[TMR_RED_LED_ST], tmr[TMR_RED_LED_END]);
  wire ir_win  = in_window(cnt, tmr[TMR_IR_LED_ST], tmr[TMR_IR_LED_END]);
  wire amb_win = in_window(cnt, tmr[TMR_RED_AMB_ST], tmr[TMR_RED_AMB_END])
               | in_window(cnt, tmr[TMR_IR_AMB_ST], tmr[TMR_IR_AMB_END]);
  wire next_led_active = timing_engine_enable & (red_win | ir_win) & ~amb_win;

  wire       adc_rst_w = |rst_win;
  wire       rst_rise  = adc_rst_w & ~ADC_RESET;
  wire       rst_fall  = ~adc_rst_w & ADC_RESET;
  wire [1:0] rise_ix   = rst_win[1] ? 2'h1 : rst_win[2] ? 2'h2 : rst_win[3] ? 2'h3 : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion phase and averaging

  logic                phase_open;
  logic [1:0]          phase_ix;
  logic [1:0]          last_ix;
  logic [11:0]         conv_tmr;
  logic [7:0]          conv_issued;
  logic [SUM_BITS-1:0] acc;
  wire                 fifo_valid;
  wire [CODE_BITS-1:0] fifo_data;
  // Samples drain only inside an open phase; otherwise the buffer fills
  wire                 take = phase_open & ~rst_rise & timing_engine_enable;
  wire                 pop  = take & fifo_valid;
  wire                 conv_due = phase_open & (conv_tmr == '0) & (conv_issued < avg_count);

  wire [8:0]                  divisor = (avg_count == 8'h00) ? 9'h001 : {1'b0, avg_count};
  wire signed [SUM_BITS-1:0]  quot    = $signed(acc) / $signed(divisor);
  // Sign extension keeps the 24-bit word a valid twos-complement value
  wire [23:0]                 avg_word = {{2{quot[CODE_BITS-1]}}, quot[CODE_BITS-1:0]};
  wire [23:0]                 comb_one = 24'(result[0] - result[1]);
  wire [23:0]                 comb_two = 24'(result[2] - avg_word);
  wire                        commit   = rst_rise & phase_open;

  afeav_fifo #(
    .WIDTH (CODE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_valid  (ADC_SAMPLE_VALID),
    .in_ready  (ADC_SAMPLE_READY),
    .in_data   (ADC_SAMPLE_DATA),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_data)
  );

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ADC_RESET        <= 1'b0;
      LED_DRIVE_ACTIVE <= 1'b0;
      RED_EMITTER_ON   <= 1'b0;
      INFRARED_EMITTER_ON <= 1'b0;
      phase_open       <= 1'b0;
      phase_ix         <= '0;
      last_ix          <= '0;
      conv_tmr         <= '0;
      conv_issued      <= '0;
      ADC_CONV_START   <= 1'b0;
      acc              <= '0;
    end
    else
    begin
      ADC_RESET           <= adc_rst_w;
      LED_DRIVE_ACTIVE    <= next_led_active;
      RED_EMITTER_ON      <= next_led_active & red_win;
      INFRARED_EMITTER_ON <= next_led_active & ir_win;
      ADC_CONV_START      <= conv_due;
      if (rst_rise)
        last_ix <= rise_ix;
      if (rst_fall)
      begin
        phase_open  <= 1'b1;
        phase_ix    <= last_ix;
        conv_tmr    <= '0;
        conv_issued <= '0;
        acc         <= '0;
      end
      else if (rst_rise | ~timing_engine_enable)
        phase_open <= 1'b0;
      else if (phase_open)
      begin
        conv_tmr <= (conv_tmr == 12'(CONV_CYCLES - 1)) ? '0 : conv_tmr + 1'b1;
        if (conv_due)
          conv_issued <= conv_issued + 1'b1;
        if (pop)
          acc <= acc + SUM_BITS'($signed(fifo_data));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result writeback and ready strobe

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < 6; i++)
        result[i] <= '0;
      phase_valid <= '0;
      ADC_RDY     <= 1'b0;
    end
    else
    begin
      ADC_RDY <= commit & (phase_ix == 2'h3) & (&phase_valid[2:0]);
      if (commit)
      begin
        result[phase_ix]         <= avg_word;
        phase_valid[phase_ix]    <= 1'b1;
        if (phase_ix == 2'h3)
        begin
          result[4] <= comb_one;
          result[5] <= comb_two;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/afeav_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module afeav_properties
  import afeav_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
)
(
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // Serial port
  input wire logic       SPI_SCLK,
  input wire logic       SPI_CS_N,
  input wire logic       SPI_MISO,
  // Converter
  input wire logic       ADC_RESET,
  input wire logic       ADC_CONV_START,
  input wire logic       ADC_SAMPLE_VALID,
  input wire logic       ADC_SAMPLE_READY,
  input wire logic       ADC_RDY,
  // LED drive
  input wire logic       LED_DRIVE_ACTIVE,
  input wire logic       RED_EMITTER_ON,
  input wire logic       INFRARED_EMITTER_ON,
  input wire logic [7:0] RED_EMITTER_CURRENT,
  input wire logic [7:0] INFRARED_EMITTER_CURRENT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last ready strobe
  logic [15:0] since_rdy;
  logic        rdy_seen;
  wire  [15:0] period_len = TMR_RESET[TMR_PERIOD] + 16'h0001;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      since_rdy <= 16'h0000;
      rdy_seen  <= 1'b0;
    end
    else
    begin
      since_rdy <= ADC_RDY ? 16'h0001 : since_rdy + 16'h0001;
      rdy_seen  <= rdy_seen | ADC_RDY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_conv_after_fall: assert property ($fell(ADC_RESET) |-> ##1 ADC_CONV_START)
    else $error("no conversion start after converter reset fell");
  a_conv_single: assert property (ADC_CONV_START |=> !ADC_CONV_START)
    else $error("conversion start longer than one cycle");
  a_conv_in_phase: assert property (ADC_CONV_START |-> !ADC_RESET)
    else $error("conversion start during converter reset");
  a_rdy_single: assert property (ADC_RDY |=> !ADC_RDY)
    else $error("ready strobe longer than one cycle");
  a_rdy_at_commit: assert property (ADC_RDY |-> ADC_RESET || $past(ADC_RESET))
    else $error("ready strobe away from start-of-period pulse");
  a_rdy_per_period: assert property (ADC_RDY && rdy_seen |-> since_rdy == period_len)
    else $error("ready strobe spacing differs from period");
  a_led_gate: assert property (RED_EMITTER_ON || INFRARED_EMITTER_ON |-> LED_DRIVE_ACTIVE)
    else $error("emitter on without drive active");
  a_miso_on_low: assert property ($changed(SPI_MISO) |-> !SPI_SCLK)
    else $error("serial output changed while serial clock high");
  a_current_by_write: assert property ($changed({RED_EMITTER_CURRENT, INFRARED_EMITTER_CURRENT}) |-> !SPI_CS_N)
    else $error("emitter current changed outside a serial write");

  c_ready: cover property (ADC_RDY);
  c_conv: cover property ($fell(ADC_RESET) ##1 ADC_CONV_START);
  c_full: cover property (ADC_SAMPLE_VALID && !ADC_SAMPLE_READY);
endmodule

bind afeav_top afeav_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.CLK_SYS(CLK_SYS), .RST(RST),
  .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO), .ADC_RESET(ADC_RESET),
  .ADC_CONV_START(ADC_CONV_START), .ADC_SAMPLE_VALID(ADC_SAMPLE_VALID), .ADC_SAMPLE_READY(ADC_SAMPLE_READY),
  .ADC_RDY(ADC_RDY), .LED_DRIVE_ACTIVE(LED_DRIVE_ACTIVE), .RED_EMITTER_ON(RED_EMITTER_ON),
  .INFRARED_EMITTER_ON(INFRARED_EMITTER_ON), .RED_EMITTER_CURRENT(RED_EMITTER_CURRENT),
  .INFRARED_EMITTER_CURRENT(INFRARED_EMITTER_CURRENT));

`default_nettype wire

// ---- test/afeav_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module afeav_host_model
(
  // Clock
  input  wire logic        clk,
  // Serial port
  output logic             sclk,
  output logic             cs_n,
  output logic             mosi,
  input  wire logic        miso,
  // Read result
  output logic             rd_done,
  output logic [23:0]      rd_data
);
  initial
  begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
    rd_done = 1'b0;
    rd_data = 24'h000000;
  end

  // One word per select, MSB first; serial clock levels last 3 to 4 cycles
  task automatic xfer(input logic [7:0] a, input logic [23:0] d, input logic rd);
    logic [31:0] w;
    w = {a, d};
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge clk) mosi <= w[i];
      @(posedge clk) sclk <= 1'b1;
      if (i < 24)
        rd_data[i] <= miso;
      repeat (2) @(posedge clk);
      @(posedge clk) sclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    cs_n    <= 1'b1;
    mosi    <= ~mosi;
    rd_done <= rd;
    @(posedge clk) rd_done <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import afeav_pkg::*;

  logic        clk, rst, sclk, cs_n, mosi, miso, adc_reset, conv_start;
  logic        s_valid, s_ready, adc_rdy, led_act, red_on, ir_on, rd_done;
  logic [21:0] s_data;
  logic [7:0]  red_cur, ir_cur;
  logic [23:0] rd_data, v;
  logic [23:0] res [0:5];
  logic [23:0] exp_r [0:5];
  logic [23:0] exp_q [$];
  longint      sum = 0;
  longint      q;
  int          ph, nfall = 0, n, nled = 0, err_count = 0, total_checks = 0;
  bit          open_ph = 0, prev_o = 0;

  afeav_top #(.FIFO_DEPTH(8)) DUT (.CLK_SYS(clk), .RST(rst), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .ADC_RESET(adc_reset), .ADC_CONV_START(conv_start),
    .ADC_SAMPLE_VALID(s_valid), .ADC_SAMPLE_READY(s_ready), .ADC_SAMPLE_DATA(s_data), .ADC_RDY(adc_rdy),
    .LED_DRIVE_ACTIVE(led_act), .RED_EMITTER_ON(red_on), .INFRARED_EMITTER_ON(ir_on),
    .RED_EMITTER_CURRENT(red_cur), .INFRARED_EMITTER_CURRENT(ir_cur));

  afeav_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .rd_done(rd_done), .rd_data(rd_data));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    host.xfer(a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    host.xfer(a, 24'h000000, 1'b1);
  endtask

  // Hold each sample until taken; a fresh random code only after acceptance
  task automatic push(input int cnt);
    logic [31:0] r;
    int k;
    k = 0;
    r = $urandom;
    while (cnt > 0)
    begin
      s_valid <= 1'b1;
      s_data  <= {r[20], r[20:0]};
      @(posedge clk);
      if (s_ready === 1'b1)
      begin
        cnt--;
        r = $urandom;
      end
      else if (++k > 20000)
      begin
        err_count++;
        close_out();
      end
    end
    s_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Expected results, tracked from accepted samples and converter reset edges
  always @(posedge clk)
  begin
    if (s_valid && s_ready)
      sum += longint'($signed(s_data));
    if (adc_reset && !prev_o && open_ph)
    begin
      q = sum / 2;
      res[ph] = {{2{q[21]}}, q[21:0]};
      if (ph == 3)
      begin
        res[4] = res[0] - res[1];
        res[5] = res[2] - res[3];
      end
      sum = 0;
      open_ph = 0;
    end
    if (!adc_reset && prev_o)
    begin
      ph = nfall % 4;
      nfall++;
      open_ph = 1;
    end
    prev_o = adc_reset;
  end

  always @(posedge clk)
    if (conv_start === 1'b1)
      fork
        push(2);
      join_none

  always @(posedge clk)
    if (rd_done === 1'b1)
      check(rd_data, exp_q.pop_front());

  // LED drive cycles between two ready strobes equal the programmed emitter windows
  always @(posedge clk)
    if (adc_rdy === 1'b1)
    begin
      check(24'(nled), 24'(TMR_RESET[TMR_RED_LED_END] - TMR_RESET[TMR_RED_LED_ST]
                         + TMR_RESET[TMR_IR_LED_END] - TMR_RESET[TMR_IR_LED_ST] + 2));
      nled = 0;
    end
    else
      nled += int'(led_act === 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    s_valid = 1'b0;
    s_data = 22'h000000;
    void'($urandom(35749));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({20'h00000, s_ready, adc_reset, conv_start, adc_rdy}, 24'h000008);
    wr(ADDR_CONTROL0, 24'h000001);
    rd(ADDR_AVG_COUNT, 24'h000002);
    rd(ADDR_TMR_FIRST + 8'h1c, {8'h00, TMR_RESET[TMR_PERIOD]});
    rd(8'h40, 24'h000000);
    wr(ADDR_LED_CURRENT, 24'h00ffff);
    rd(ADDR_LED_CURRENT, 24'h000000);
    wr(ADDR_CONTROL0, 24'h000000);
    v = $urandom;
    wr(ADDR_LED_CURRENT, {8'h00, v[15:0]});
    check({16'h0000, red_cur}, {16'h0000, v[7:0]});
    check({16'h0000, ir_cur}, {16'h0000, v[15:8]});
    push(8);
    @(posedge clk);
    check({23'h000000, s_ready}, 24'h000000);
    // Six-clock converter resets; first conversion of each phase starts one clock after its reset ends
    for (int k = 0; k < 4; k++)
    begin
      wr(8'(TMR_CONV_RST_ST + 1 + 2*k), {8'h00, TMR_RESET[TMR_CONV_RST_ST + 1 + 2*k] + 16'h0002});
      wr(8'h0d + 8'(2*k), {8'h00, TMR_RESET[13 + 2*k] + 16'h0002});
    end
    wr(ADDR_FIRST_CONTROL, 24'h000001);
    repeat (2)
    begin
      n = 0;
      while (adc_rdy !== 1'b1 && n < 20000)
      begin
        @(posedge clk);
        n++;
      end
      if (n >= 20000)
      begin
        err_count++;
        close_out();
      end
      // Let the model finish its commit bookkeeping before copying it
      @(posedge clk);
      exp_r = res;
      wr(ADDR_CONTROL0, 24'h000001);
      for (int i = 0; i < 6; i++)
        rd(ADDR_PHASE_ONE + 8'(i), exp_r[i]);
      wr(ADDR_CONTROL0, 24'h000000);
    end
    wr(ADDR_FIRST_CONTROL, 24'h000000);
    repeat (4) @(posedge clk);
    check(24'(exp_q.size()), 24'h000000);
    close_out();
  end
endmodule

`default_nettype wire
